// File: pgs_pkg.sv
// Constants, field positions and types of the gigabit status and indirect access slice.
// Assumes a management serial frame engine in the same device reads these names.

package pgs_pkg;

   // ----------------------------------------------------------------
   // Register offsets
   // ----------------------------------------------------------------
   localparam logic [4:0]  OFS_CFG_ONE       = 5'h09;
   localparam logic [4:0]  OFS_LINK_STATUS   = 5'h0a;
   localparam logic [4:0]  OFS_ACC_CTRL      = 5'h0d;
   localparam logic [4:0]  OFS_ADDR_DATA     = 5'h0e;
   localparam logic [4:0]  OFS_LOCAL_CAP     = 5'h0f;

   // ----------------------------------------------------------------
   // Reset values and masks
   // ----------------------------------------------------------------
   localparam logic [15:0] CFG_ONE_RESET     = 16'h0300;
   localparam logic [15:0] CFG_ONE_WMASK     = 16'hff80;
   localparam logic [15:0] CTRL_WMASK        = 16'hc01f;
   localparam logic [15:0] CTRL_RESET        = 16'h0000;
   localparam logic [15:0] ADDR_DATA_RESET   = 16'h0000;
   localparam logic [15:0] LOCAL_CAP_VALUE   = 16'h3000;
   localparam logic [15:0] EXT_RESET         = 16'h0000;
   localparam logic [7:0]  IDLE_CNT_RESET    = 8'h00;
   localparam logic [7:0]  IDLE_CNT_MAX      = 8'hff;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int          STS_MASTER_BIT    = 14;
   localparam int          STS_LOC_RX_BIT    = 13;
   localparam int          STS_REM_RX_BIT    = 12;
   localparam int          STS_LP_FULL_BIT   = 11;
   localparam int          STS_LP_HALF_BIT   = 10;
   localparam int          STS_CNT_MSB       = 7;
   localparam int          CTRL_FUNC_MSB     = 15;
   localparam int          CTRL_FUNC_LSB     = 14;
   localparam int          CTRL_DEV_MSB      = 4;

   // ----------------------------------------------------------------
   // Indirect access codes
   // ----------------------------------------------------------------
   localparam logic [1:0]  FN_ADDRESS        = 2'b00;
   localparam logic [1:0]  FN_DATA_HOLD      = 2'b01;
   localparam logic [1:0]  FN_DATA_INC_RW    = 2'b10;
   localparam logic [1:0]  FN_DATA_INC_WR    = 2'b11;
   localparam logic [4:0]  DEV_SELECT_OWN    = 5'h1f;
   localparam logic [15:0] EXT_BASE          = 16'h0020;
   localparam logic [15:0] PTR_STEP          = 16'h0001;

   // ----------------------------------------------------------------
   // Management frame
   // ----------------------------------------------------------------
   localparam logic [1:0]  FRM_START         = 2'b01;
   localparam logic [1:0]  FRM_OP_RD         = 2'b10;
   localparam logic [1:0]  FRM_OP_WR         = 2'b01;
   localparam logic [5:0]  PRE_LEN           = 6'd32;
   localparam logic [4:0]  HDR_LAST          = 5'd13;
   localparam logic [4:0]  DATA_LAST         = 5'd15;
   localparam logic [4:0]  PHY_ADDR_DEFAULT  = 5'h01;

   typedef enum logic [1:0] {ST_PRE, ST_HDR, ST_TA, ST_DATA} pgs_frame_t;

endpackage

// File: pgs_mgmt_regs.sv
// Management register slice: serial frame engine, gigabit status,
// indirect extended access window and local capability register.
// Assumes mdc and mdio_in are synchronous to mclk; the pad merges
// mdio_out and mdio_oe into the shared data wire.

module pgs_mgmt_regs
   import pgs_pkg::*;
#(
   parameter logic [4:0] PHY_ADDR  = pgs_pkg::PHY_ADDR_DEFAULT,
   parameter int         EXT_DEPTH = 16
) (
   input  wire logic        mclk,
   input  wire logic        arst_n,
   input  wire logic        mdc,
   input  wire logic        mdio_in,
   output logic             mdio_out,
   output logic             mdio_oe,
   input  wire logic        ms_resolved_master,
   input  wire logic        local_rx_ok,
   input  wire logic        remote_rx_ok,
   input  wire logic        lp_gig_full,
   input  wire logic        lp_gig_half,
   input  wire logic        idle_error,
   output logic [15:0]      cfg_one
);
   import pgs_pkg::*;

   localparam int IDX_W = (EXT_DEPTH > 1) ? $clog2(EXT_DEPTH) : 1;

   pgs_frame_t        state_reg;
   logic              mdc_prev_reg;
   logic [5:0]        pre_cnt_reg;
   logic [4:0]        bit_cnt_reg;
   logic [13:0]       hdr_reg;
   logic              is_read_reg;
   logic [4:0]        reg_sel_reg;
   logic [15:0]       wr_shift_reg;
   logic [15:0]       rd_shift_reg;
   logic              mdio_out_reg;
   logic              mdio_oe_reg;
   logic [15:0]       cfg_reg;
   logic [15:0]       ctrl_reg;
   logic [15:0]       ptr_reg;
   logic [15:0]       ptr_next;
   logic [7:0]        idle_cnt_reg;
   logic [15:0]       ext_mem [EXT_DEPTH];

   logic              mdc_rise;
   logic [13:0]       hdr_word;
   logic              hdr_last;
   logic              hdr_ok;
   logic              rd_go;
   logic              wr_go;
   logic [15:0]       wr_word;
   logic [4:0]        rd_sel;
   logic [15:0]       rd_value;
   logic [15:0]       status_word;
   logic [1:0]        func;
   logic              dev_ok;
   logic [15:0]       ext_off;
   logic              ext_hit;
   logic [IDX_W-1:0]  ext_idx;
   logic [15:0]       ext_rd;
   logic              win_rd;
   logic              win_wr;
   logic              ptr_load;
   logic              ptr_inc;

   // ----------------------------------------------------------------
   // Frame decode
   // ----------------------------------------------------------------
   assign mdc_rise  = mdc && !mdc_prev_reg;
   assign hdr_word  = {hdr_reg[12:0], mdio_in};
   assign hdr_last  = mdc_rise && (state_reg == ST_HDR) && (bit_cnt_reg == HDR_LAST);
   assign hdr_ok    = (hdr_word[13:12] == FRM_START)
                    && ((hdr_word[11:10] == FRM_OP_RD) || (hdr_word[11:10] == FRM_OP_WR))
                    && (hdr_word[9:5] == PHY_ADDR);
   assign rd_sel    = hdr_word[4:0];
   assign rd_go     = hdr_last && hdr_ok && (hdr_word[11:10] == FRM_OP_RD);
   assign wr_go     = mdc_rise && (state_reg == ST_DATA) && !is_read_reg
                    && (bit_cnt_reg == DATA_LAST);
   assign wr_word   = {wr_shift_reg[14:0], mdio_in};

   // ----------------------------------------------------------------
   // Indirect window decode
   // ----------------------------------------------------------------
   assign func      = ctrl_reg[CTRL_FUNC_MSB:CTRL_FUNC_LSB];
   assign dev_ok    = (ctrl_reg[CTRL_DEV_MSB:0] == DEV_SELECT_OWN);
   assign ext_off   = ptr_reg - EXT_BASE;
   assign ext_hit   = (ptr_reg >= EXT_BASE) && ({16'h0000, ext_off} < 32'(EXT_DEPTH));
   assign ext_idx   = ext_off[IDX_W-1:0];
   assign ext_rd    = ext_hit ? ext_mem[ext_idx] : 16'h0000;
   assign win_rd    = rd_go && (rd_sel == OFS_ADDR_DATA) && dev_ok && (func != FN_ADDRESS);
   assign win_wr    = wr_go && (reg_sel_reg == OFS_ADDR_DATA) && dev_ok;
   assign ptr_load  = win_wr && (func == FN_ADDRESS);
   assign ptr_inc   = (win_rd && (func == FN_DATA_INC_RW))
                    || (win_wr && ((func == FN_DATA_INC_RW) || (func == FN_DATA_INC_WR)));
   assign ptr_next  = ptr_reg + PTR_STEP;

   // ----------------------------------------------------------------
   // Read data
   // ----------------------------------------------------------------
   always_comb begin
      status_word                  = 16'h0000;
      status_word[STS_MASTER_BIT]  = ms_resolved_master;
      status_word[STS_LOC_RX_BIT]  = local_rx_ok;
      status_word[STS_REM_RX_BIT]  = remote_rx_ok;
      status_word[STS_LP_FULL_BIT] = lp_gig_full;
      status_word[STS_LP_HALF_BIT] = lp_gig_half;
      status_word[STS_CNT_MSB:0]   = idle_cnt_reg;
   end

   always_comb begin
      unique case (rd_sel)
         OFS_CFG_ONE:     rd_value = cfg_reg;
         OFS_LINK_STATUS: rd_value = status_word;
         OFS_ACC_CTRL:    rd_value = ctrl_reg;
         OFS_ADDR_DATA: begin
            if (!dev_ok) begin
               rd_value = 16'h0000;
            end else if (func == FN_ADDRESS) begin
               rd_value = ptr_reg;
            end else begin
               rd_value = ext_rd;
            end
         end
         OFS_LOCAL_CAP:   rd_value = LOCAL_CAP_VALUE;
         default:         rd_value = 16'h0000;
      endcase
   end

   // ----------------------------------------------------------------
   // Clock edge detect
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         mdc_prev_reg <= 1'b0;
      end else begin
         mdc_prev_reg <= mdc;
      end
   end

   // ----------------------------------------------------------------
   // Frame engine
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg    <= ST_PRE;
         pre_cnt_reg  <= 6'd0;
         bit_cnt_reg  <= 5'd0;
         hdr_reg      <= 14'h0000;
         is_read_reg  <= 1'b0;
         reg_sel_reg  <= 5'h00;
         wr_shift_reg <= 16'h0000;
         rd_shift_reg <= 16'h0000;
         mdio_out_reg <= 1'b0;
         mdio_oe_reg  <= 1'b0;
      end else if (mdc_rise) begin
         unique case (state_reg)
            ST_PRE: begin
               if (mdio_in) begin
                  if (pre_cnt_reg < PRE_LEN) begin
                     pre_cnt_reg <= pre_cnt_reg + 6'd1;
                  end
               end else begin
                  pre_cnt_reg <= 6'd0;
                  if (pre_cnt_reg >= PRE_LEN) begin
                     state_reg   <= ST_HDR;
                     hdr_reg     <= 14'h0000;
                     bit_cnt_reg <= 5'd1;
                  end
               end
            end
            ST_HDR: begin
               hdr_reg     <= hdr_word;
               bit_cnt_reg <= bit_cnt_reg + 5'd1;
               if (bit_cnt_reg == HDR_LAST) begin
                  bit_cnt_reg  <= 5'd0;
                  reg_sel_reg  <= rd_sel;
                  is_read_reg  <= (hdr_word[11:10] == FRM_OP_RD);
                  rd_shift_reg <= rd_value;
                  state_reg    <= hdr_ok ? ST_TA : ST_PRE;
               end
            end
            ST_TA: begin
               if (bit_cnt_reg == 5'd0) begin
                  bit_cnt_reg <= 5'd1;
                  if (is_read_reg) begin
                     mdio_oe_reg  <= 1'b1;
                     mdio_out_reg <= 1'b0;
                  end
               end else begin
                  bit_cnt_reg <= 5'd0;
                  state_reg   <= ST_DATA;
                  if (is_read_reg) begin
                     mdio_out_reg <= rd_shift_reg[15];
                     rd_shift_reg <= {rd_shift_reg[14:0], 1'b0};
                  end
               end
            end
            ST_DATA: begin
               bit_cnt_reg  <= bit_cnt_reg + 5'd1;
               wr_shift_reg <= wr_word;
               if (is_read_reg) begin
                  mdio_out_reg <= rd_shift_reg[15];
                  rd_shift_reg <= {rd_shift_reg[14:0], 1'b0};
               end
               if (bit_cnt_reg == DATA_LAST) begin
                  bit_cnt_reg  <= 5'd0;
                  state_reg    <= ST_PRE;
                  mdio_oe_reg  <= 1'b0;
                  mdio_out_reg <= 1'b0;
               end
            end
         endcase
      end
   end

   assign mdio_out = mdio_out_reg;
   assign mdio_oe  = mdio_oe_reg;

   // ----------------------------------------------------------------
   // Direct registers
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_reg  <= CFG_ONE_RESET;
         ctrl_reg <= CTRL_RESET;
      end else if (wr_go) begin
         if (reg_sel_reg == OFS_CFG_ONE) begin
            cfg_reg <= wr_word & CFG_ONE_WMASK;
         end
         if (reg_sel_reg == OFS_ACC_CTRL) begin
            ctrl_reg <= wr_word & CTRL_WMASK;
         end
      end
   end

   assign cfg_one = cfg_reg;

   // ----------------------------------------------------------------
   // Idle error counter
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         idle_cnt_reg <= IDLE_CNT_RESET;
      end else if (rd_go && (rd_sel == OFS_LINK_STATUS)) begin
         idle_cnt_reg <= idle_error ? 8'h01 : IDLE_CNT_RESET;
      end else if (idle_error && (idle_cnt_reg != IDLE_CNT_MAX)) begin
         idle_cnt_reg <= idle_cnt_reg + 8'h01;
      end
   end

   // ----------------------------------------------------------------
   // Extended address pointer
   // ----------------------------------------------------------------
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ptr_reg <= ADDR_DATA_RESET;
      end else if (ptr_load) begin
         ptr_reg <= wr_word;
      end else if (ptr_inc) begin
         ptr_reg <= ptr_next;
      end
   end

   // ----------------------------------------------------------------
   // Extended register storage
   // ----------------------------------------------------------------
   for (genvar g = 0; g < EXT_DEPTH; g++) begin : g_ext
      always_ff @(posedge mclk or negedge arst_n) begin
         if (!arst_n) begin
            ext_mem[g] <= EXT_RESET;
         end else if (win_wr && (func != FN_ADDRESS) && ext_hit
                      && (ext_idx == IDX_W'(g))) begin
            ext_mem[g] <= wr_word;
         end
      end
   end

endmodule

// File: pgs_mgmt_regs_assertions.sv
// Checker for the management register slice.
// Bound to pgs_mgmt_regs; sees its ports only.
module pgs_mgmt_regs_chk #(
   parameter logic [4:0] PHY_ADDR  = 5'h01,
   parameter int         EXT_DEPTH = 16
) (
   input wire logic        mclk,
   input wire logic        arst_n,
   input wire logic        mdc,
   input wire logic        mdio_in,
   input wire logic        mdio_out,
   input wire logic        mdio_oe,
   input wire logic        ms_resolved_master,
   input wire logic        local_rx_ok,
   input wire logic        remote_rx_ok,
   input wire logic        lp_gig_full,
   input wire logic        lp_gig_half,
   input wire logic        idle_error,
   input wire logic [15:0] cfg_one
);
   timeunit 1ns;
   timeprecision 1ns;
   import pgs_pkg::*;
   logic        mdc_q, rise, hdr, rd_hdr, rd_pend;
   logic [63:0] sh, nsh;
   logic [4:0]  lreg, rcnt;
   logic [15:0] dsh;
   logic [7:0]  mcnt, snap;
   assign rise = mdc && !mdc_q;
   assign nsh = {sh[62:0], mdio_in};
   assign hdr = rise && (nsh[45:12] == {32'hffffffff, 2'b01});
   assign rd_hdr = hdr && nsh[11:10] == 2'b10 && nsh[9:5] == PHY_ADDR;
   // ----
   // Frame tracking
   // ----
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         mdc_q <= 1'b0;
         sh    <= '0;
      end else begin
         mdc_q <= mdc;
         if (rise) sh <= nsh;
      end
   end
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rd_pend <= 1'b0;
         lreg    <= 5'h00;
      end else if (rd_hdr) begin
         rd_pend <= 1'b1;
         lreg    <= nsh[4:0];
      end else if (rise && mdio_oe) rd_pend <= 1'b0;
   end
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rcnt <= 5'h00;
         dsh  <= 16'h0000;
      end else if (!mdio_oe) rcnt <= 5'h00;
      else if (rise) begin
         rcnt <= rcnt + 5'h01;
         dsh  <= {dsh[14:0], mdio_out};
      end
   end
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         mcnt <= 8'h00;
         snap <= 8'h00;
      end else if (rd_hdr && nsh[4:0] == 5'h0a) begin
         snap <= mcnt;
         mcnt <= {7'h00, idle_error};
      end else if (idle_error && mcnt != 8'hff) mcnt <= mcnt + 8'h01;
   end
   // ----
   // Assertions
   // ----
   default clocking @(posedge mclk); endclocking
   default disable iff (!arst_n);
   AST_OE_ONLY_READ: assert property ($rose(mdio_oe) |-> rd_pend)
      else $error("output enable rose outside a read");
   AST_READ_LEN: assert property ($fell(mdio_oe) |-> rcnt == 5'd17)
      else $error("read drive length wrong");
   AST_STS_LIVE: assert property ($fell(mdio_oe) && lreg == 5'h0a |-> dsh[15:10] ==
      {1'b0, ms_resolved_master, local_rx_ok, remote_rx_ok, lp_gig_full, lp_gig_half})
      else $error("status bits differ from inputs");
   AST_STS_RSVD: assert property ($fell(mdio_oe) && lreg == 5'h0a |-> dsh[9:8] == 2'b00)
      else $error("status reserved bits set");
   AST_IDLE_CNT: assert property ($fell(mdio_oe) && lreg == 5'h0a |-> dsh[7:0] == snap)
      else $error("idle error count wrong");
   AST_CAP_FIXED: assert property ($fell(mdio_oe) && lreg == 5'h0f |-> dsh == 16'h3000)
      else $error("capability value wrong");
   AST_CTRL_RSVD: assert property ($fell(mdio_oe) && lreg == 5'h0d |-> dsh[13:5] == 9'h000)
      else $error("control reserved bits set");
   AST_UNMAPPED: assert property ($fell(mdio_oe) && !(lreg inside {5'h09, 5'h0a, 5'h0d,
      5'h0e, 5'h0f}) |-> dsh == 16'h0000) else $error("unmapped read not zero");
   AST_CFG_RSVD: assert property (cfg_one[6:0] == 7'h00)
      else $error("config reserved bits set");
endmodule

bind pgs_mgmt_regs pgs_mgmt_regs_chk #(.PHY_ADDR(PHY_ADDR), .EXT_DEPTH(EXT_DEPTH)) u_chk (
   .mclk(mclk), .arst_n(arst_n), .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out),
   .mdio_oe(mdio_oe), .ms_resolved_master(ms_resolved_master), .local_rx_ok(local_rx_ok),
   .remote_rx_ok(remote_rx_ok), .lp_gig_full(lp_gig_full), .lp_gig_half(lp_gig_half),
   .idle_error(idle_error), .cfg_one(cfg_one));

// File: pgs_mgmt_host.sv
// Station manager model: serial management frames.
// Assumes the shared data wire has a pull-up.
module pgs_mgmt_host (
   input wire logic mclk,
   input wire logic mdio_out,
   input wire logic mdio_oe,
   output logic     mdc,
   output logic     mdio_line
);
   timeunit 1ns;
   timeprecision 1ns;
   logic host_oe = 1'b0;
   logic host_d = 1'b1;
   initial mdc = 1'b0;
   assign mdio_line = mdio_oe ? mdio_out : (host_oe ? host_d : 1'b1);
   // One frame, 3 cycles low and 3 high per bit
   task automatic xfer(input logic rd, input logic [4:0] ra, input logic [15:0] wd,
                       output logic [15:0] rv);
      logic [63:0] frm;
      frm = {32'hffffffff, 2'b01, rd ? 2'b10 : 2'b01, 5'h01, ra, 2'b10, wd};
      rv = 16'h0000;
      for (int i = 0; i < 64; i++) begin
         @(posedge mclk);
         mdc <= 1'b0;
         host_oe <= !(rd && i >= 46);
         host_d <= frm[63-i];
         repeat (3) @(posedge mclk);
         if (rd && i >= 48) rv = {rv[14:0], mdio_line};
         mdc <= 1'b1;
         repeat (2) @(posedge mclk);
      end
   endtask
endmodule

// File: phy_gig_status_and_indirect_access_tb_top.sv
// Testbench for the management register slice.
// Assumes pgs_pkg and the host model are compiled first.
module phy_gig_status_and_indirect_access_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import pgs_pkg::*;
   logic        mclk, arst_n, mdc, mdio_line, mdio_out, mdio_oe;
   logic        ms, loc, rem, full, half, idle;
   logic [15:0] cfg_one, rdv;
   int          fail_count = 0;
   int          cmp_count = 0;
   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end
   pgs_mgmt_regs #(.PHY_ADDR(5'h01), .EXT_DEPTH(4)) dut (.mclk(mclk), .arst_n(arst_n),
      .mdc(mdc), .mdio_in(mdio_line), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
      .ms_resolved_master(ms), .local_rx_ok(loc), .remote_rx_ok(rem), .lp_gig_full(full),
      .lp_gig_half(half), .idle_error(idle), .cfg_one(cfg_one));
   pgs_mgmt_host host (.mclk(mclk), .mdio_out(mdio_out), .mdio_oe(mdio_oe), .mdc(mdc),
      .mdio_line(mdio_line));
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // Write, or read and compare
   task automatic acc(input logic rd, input logic [4:0] ra, input logic [15:0] v);
      host.xfer(rd, ra, v, rdv);
      if (rd) check($sformatf("reg %h", ra), rdv, v);
   endtask
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge mclk);
      fail_count++;
      summarize();
   end
   initial begin
      arst_n = 1'b0;
      {ms, loc, rem, full, half, idle} = 6'b110100;
      repeat (16) @(posedge mclk);
      arst_n <= 1'b1;
      check("cfg_one", cfg_one, 16'h0300);
      acc(1'b1, OFS_CFG_ONE, 16'h0300);
      acc(1'b0, OFS_LOCAL_CAP, 16'hffff);
      acc(1'b1, OFS_LOCAL_CAP, 16'h3000);
      acc(1'b1, OFS_ACC_CTRL, 16'h0000);
      repeat (5) begin
         @(posedge mclk) idle <= 1'b1;
         @(posedge mclk) idle <= 1'b0;
      end
      acc(1'b1, OFS_LINK_STATUS, 16'h6805);
      @(posedge mclk) {ms, loc, rem, full, half} <= 5'b01101;
      acc(1'b0, OFS_LINK_STATUS, 16'hffff);
      acc(1'b1, OFS_LINK_STATUS, 16'h3400);
      acc(1'b0, OFS_CFG_ONE, 16'hffff);
      acc(1'b1, OFS_CFG_ONE, 16'hff80);
      check("cfg_one", cfg_one, 16'hff80);
      acc(1'b0, OFS_ACC_CTRL, 16'hffff);
      acc(1'b1, OFS_ACC_CTRL, 16'hc01f);
      acc(1'b1, 5'h10, 16'h0000);
      acc(1'b0, OFS_ACC_CTRL, 16'h001f);
      acc(1'b0, OFS_ADDR_DATA, 16'h0021);
      acc(1'b1, OFS_ADDR_DATA, 16'h0021);
      acc(1'b0, OFS_ACC_CTRL, 16'h401f);
      acc(1'b0, OFS_ADDR_DATA, 16'haaaa);
      acc(1'b1, OFS_ADDR_DATA, 16'haaaa);
      acc(1'b1, OFS_ADDR_DATA, 16'haaaa);
      acc(1'b0, OFS_ACC_CTRL, 16'h801f);
      acc(1'b0, OFS_ADDR_DATA, 16'h1111);
      acc(1'b1, OFS_ADDR_DATA, 16'h0000);
      acc(1'b0, OFS_ACC_CTRL, 16'h001f);
      acc(1'b1, OFS_ADDR_DATA, 16'h0023);
      acc(1'b0, OFS_ACC_CTRL, 16'hc01f);
      acc(1'b1, OFS_ADDR_DATA, 16'h0000);
      acc(1'b0, OFS_ADDR_DATA, 16'h2222);
      acc(1'b0, OFS_ACC_CTRL, 16'h001f);
      acc(1'b1, OFS_ADDR_DATA, 16'h0024);
      acc(1'b0, OFS_ADDR_DATA, 16'h0021);
      acc(1'b0, OFS_ACC_CTRL, 16'h801f);
      acc(1'b1, OFS_ADDR_DATA, 16'h1111);
      acc(1'b1, OFS_ADDR_DATA, 16'h0000);
      acc(1'b1, OFS_ADDR_DATA, 16'h2222);
      acc(1'b0, OFS_ACC_CTRL, 16'h001e);
      acc(1'b0, OFS_ADDR_DATA, 16'h0023);
      acc(1'b1, OFS_ADDR_DATA, 16'h0000);
      acc(1'b0, OFS_ACC_CTRL, 16'h001f);
      acc(1'b1, OFS_ADDR_DATA, 16'h0024);
      acc(1'b0, OFS_ADDR_DATA, 16'hffff);
      acc(1'b0, OFS_ACC_CTRL, 16'h801f);
      acc(1'b1, OFS_ADDR_DATA, 16'h0000);
      acc(1'b0, OFS_ACC_CTRL, 16'h001f);
      acc(1'b1, OFS_ADDR_DATA, 16'h0000);
      summarize();
   end
endmodule
